/* File: verilog/cc_detect_cfg.svh */
/*
  constants of the cc attach and detach detector: byte offsets, field positions,
  reset values, threshold indices and pull-up codes.
  assumes it is included by bare name from the detector and its bench.
*/
`ifndef CC_DETECT_CFG_SVH
`define CC_DETECT_CFG_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define CCD_OFS_CTRL   5'h00
`define CCD_OFS_MATCH  5'h04
`define CCD_OFS_STATE  5'h08
`define CCD_OFS_STS    5'h0c
`define CCD_OFS_MASK   5'h10

// ----------------------------------------
// control fields and reset values
// ----------------------------------------
`define CCD_CTRL_SINK  0
`define CCD_CTRL_RP    1
`define CCD_CTRL_VHC   3
`define CCD_CTRL_RST   4'h2
`define CCD_MASK_RST   4'h0

// ----------------------------------------
// state word and match register fields
// ----------------------------------------
`define CCD_ST_CONN    0
`define CCD_ST_VCSEL   7
`define CCD_ST_VBUS    8
`define CCD_ST_VCONN   9
`define CCD_ST_W1      10
`define CCD_ST_W2      11
`define CCD_ST_ADV1    12
`define CCD_ST_ADV2    15
`define CCD_ST_SATT    18
`define CCD_MATCH_CC2  8

// ----------------------------------------
// event bits
// ----------------------------------------
`define CCD_EV_CC1     0
`define CCD_EV_CC2     1
`define CCD_EV_CONN    2
`define CCD_EV_SNK     3

// ----------------------------------------
// comparator threshold indices
// ----------------------------------------
`define CCD_THR_DEF    3'h0
`define CCD_THR_1A5    3'h1
`define CCD_THR_S1A5   3'h2
`define CCD_THR_3A0    3'h3
`define CCD_THR_S3A0   3'h4
`define CCD_THR_ATT    3'h5
`define CCD_THR_ATT3   3'h6
`define CCD_THR_VHC    3'h7

// ----------------------------------------
// pull-up current codes
// ----------------------------------------
`define CCD_RP_OFF     2'h0
`define CCD_RP_DEF     2'h1
`define CCD_RP_1A5     2'h2
`define CCD_RP_3A0     2'h3

`endif

/* File: verilog/cc_detect_pkg.sv */
/*
  types of the cc attach and detach detector.
  assumes nothing beyond a systemverilog compiler.
*/
`default_nettype none

package cc_detect_pkg;

  typedef enum logic [6:0] {
    CONN_NONE       = 7'h01,
    CONN_SINK       = 7'h02,
    CONN_CABLE      = 7'h04,
    CONN_CABLE_SINK = 7'h08,
    CONN_DEBUG      = 7'h10,
    CONN_AUDIO      = 7'h20,
    CONN_SNK_MODE   = 7'h40
  } conn_state_type;

  typedef enum logic [2:0] {
    LINE_OPEN = 3'h1,
    LINE_RD   = 3'h2,
    LINE_RA   = 3'h4
  } line_class_type;

  typedef enum logic [2:0] {
    ADV_NONE = 3'h0,
    ADV_DEF  = 3'h1,
    ADV_1A5  = 3'h2,
    ADV_3A0  = 3'h3,
    ADV_VHC  = 3'h4
  } adv_level_type;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [4:0]  address;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } avl_req_type;

  typedef struct packed {
    logic [7:0] m1;
    logic [7:0] m2;
    logic [1:0] chg;
  } sync_state_type;

  typedef struct packed {
    logic vbus;
    logic vconn;
    logic vconn_cc2;
    logic watch_cc1;
    logic watch_cc2;
  } port_ctl_type;

  typedef struct packed {
    logic           [3:0]  ctrl;
    conn_state_type        conn;
    port_ctl_type          pc;
    adv_level_type         adv1;
    adv_level_type         adv2;
    logic                  snk_att;
    logic           [3:0]  sts;
    logic           [3:0]  mask;
    logic           [31:0] rdata;
    logic                  ack;
    logic           [1:0]  rp_out;
    logic                  irq;
  } det_state_type;

endpackage : cc_detect_pkg

`default_nettype wire

/* File: verilog/cc_match_sync.sv */
/*
  registers the two raw comparator vectors and flags any change of them.
  assumes the comparator outputs are synchronous to clk_sys_in.
*/
`default_nettype none

module cc_match_sync (
  input  wire logic       clk_sys_in,
  input  wire logic       srst_in,
  input  wire logic [7:0] cc1_raw_in,
  input  wire logic [7:0] cc2_raw_in,
  output logic      [7:0] cc1_match_out,
  output logic      [7:0] cc2_match_out,
  output logic      [1:0] change_out
);

  cc_detect_pkg::sync_state_type st_reg;
  cc_detect_pkg::sync_state_type st_next;

  // ----------------------------------------
  // capture
  // ----------------------------------------
  always_comb begin
    st_next        = st_reg;
    st_next.m1     = cc1_raw_in;
    st_next.m2     = cc2_raw_in;
    st_next.chg[0] = cc1_raw_in != st_reg.m1;
    st_next.chg[1] = cc2_raw_in != st_reg.m2;
    if (srst_in) begin
      st_next = '0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    st_reg <= st_next;
  end

  assign cc1_match_out = st_reg.m1;
  assign cc2_match_out = st_reg.m2;
  assign change_out    = st_reg.chg;

endmodule : cc_match_sync

`default_nettype wire

/* File: verilog/typec_cc_attach_detect.sv */
/*
  type-c cc attach and detach detector: classifies both cc lines from the
  threshold match vectors, drives vbus, vconn and watch controls, applies the
  pull-up current code and reports state over an avalon-mm slave.
  assumes comparator, strap and bus power sense inputs are synchronous to
  clk_sys_in, and that the analog comparator steps through all thresholds.
*/
// The address map and register access over Avalon-MM were chosen for this implementation.
// Operation
// - each cc line reports an eight-bit vector, one bit per threshold
// - source facing only an ra load reads an all-zero vector
// - source with sink attached matches threshold 0, 1 or 3 per level
// - source with open line matches 0+5, 1+5 or 3+6 per level
// - vendor high-current mode with open line matches threshold 7 only
// - sink sees 0+2 for 1.5 A, 0+2+4 for 3.0 A, plus 7 vendor
// - both lines open as source: unattached, watch both, power off
// - one rd, one open: sink attached, watch rd line, vbus on
// - one ra, one open: cable only, watch both lines, power off
// - ra plus rd: watch rd line only, vbus and vconn on
// - rd+rd debug, ra+ra audio accessory, watch both, power off
// - two-bit pull-up code: off, default, 1.5 A, 3.0 A
// - no pull-up advertisement while the configuration strap is sampled
// - sink attach uses threshold 5 for default and 1.5 A, 6 for 3.0 A
// - as sink, follow changes of the advertised source level
// - threshold 7 is kept for the vendor high-current mode
`include "cc_detect_cfg.svh"
`default_nettype none

module typec_cc_attach_detect (
  input  wire logic                        clk_sys_in,
  input  wire logic                        srst_in,
  input  wire cc_detect_pkg::avl_req_type  avl_in,
  output logic                      [31:0] avl_readdata_out,
  output logic                             avl_waitrequest_out,
  input  wire logic                 [7:0]  cc1_cmp_in,
  input  wire logic                 [7:0]  cc2_cmp_in,
  input  wire logic                        strap_sample_in,
  input  wire logic                        bus_power_sense_pin_in,
  output logic                      [1:0]  pullup_current_select_out,
  output logic                             vbus_en_out,
  output logic                             vconn_en_out,
  output logic                             vconn_cc2_out,
  output logic                             watch_cc1_out,
  output logic                             watch_cc2_out,
  output logic                             irq_out
);

  // ----------------------------------------
  // decode functions
  // ----------------------------------------
  function automatic logic [2:0] attach_thr(input logic [1:0] rp, input logic vhc);
    logic [2:0] t;
    t = `CCD_THR_ATT;
    if (vhc) begin
      t = `CCD_THR_VHC;
    end else if (rp == `CCD_RP_3A0) begin
      t = `CCD_THR_ATT3;
    end
    return t;
  endfunction : attach_thr

  function automatic cc_detect_pkg::line_class_type classify(
    input logic [7:0] m, input logic [2:0] att);
    cc_detect_pkg::line_class_type c;
    c = cc_detect_pkg::LINE_RD;
    if (m[att]) begin
      c = cc_detect_pkg::LINE_OPEN;
    end else if (m == 8'h00) begin
      c = cc_detect_pkg::LINE_RA;
    end
    return c;
  endfunction : classify

  function automatic cc_detect_pkg::adv_level_type sink_adv(input logic [7:0] m);
    cc_detect_pkg::adv_level_type a;
    a = cc_detect_pkg::ADV_NONE;
    if (m[`CCD_THR_VHC]) begin
      a = cc_detect_pkg::ADV_VHC;
    end else if (m[`CCD_THR_S3A0]) begin
      a = cc_detect_pkg::ADV_3A0;
    end else if (m[`CCD_THR_S1A5]) begin
      a = cc_detect_pkg::ADV_1A5;
    end else if (m[`CCD_THR_DEF]) begin
      a = cc_detect_pkg::ADV_DEF;
    end
    return a;
  endfunction : sink_adv

  // ----------------------------------------
  // match capture
  // ----------------------------------------
  logic [7:0] m1;
  logic [7:0] m2;
  logic [1:0] m_chg;

  cc_match_sync u_sync (
    .clk_sys_in    (clk_sys_in),
    .srst_in       (srst_in),
    .cc1_raw_in    (cc1_cmp_in),
    .cc2_raw_in    (cc2_cmp_in),
    .cc1_match_out (m1),
    .cc2_match_out (m2),
    .change_out    (m_chg)
  );

  // ----------------------------------------
  // state
  // ----------------------------------------
  cc_detect_pkg::det_state_type   st_reg;
  cc_detect_pkg::det_state_type   st_next;
  cc_detect_pkg::line_class_type  c1;
  cc_detect_pkg::line_class_type  c2;
  logic                           is_sink;
  logic [1:0]                     rp;
  logic [2:0]                     att;
  logic                           req;
  logic                           wr_ok;
  logic [31:0]                    state_word;

  assign is_sink = st_reg.ctrl[`CCD_CTRL_SINK];
  assign rp      = st_reg.ctrl[`CCD_CTRL_RP +: 2];
  assign att     = attach_thr(rp, st_reg.ctrl[`CCD_CTRL_VHC]);
  assign c1      = classify(m1, att);
  assign c2      = classify(m2, att);
  assign req     = avl_in.read | avl_in.write;
  assign wr_ok   = avl_in.write & st_reg.ack & avl_in.byteenable[0];

  always_comb begin
    state_word = '0;
    state_word[`CCD_ST_CONN +: 7] = st_reg.conn;
    state_word[`CCD_ST_VCSEL]     = st_reg.pc.vconn_cc2;
    state_word[`CCD_ST_VBUS]      = st_reg.pc.vbus;
    state_word[`CCD_ST_VCONN]     = st_reg.pc.vconn;
    state_word[`CCD_ST_W1]        = st_reg.pc.watch_cc1;
    state_word[`CCD_ST_W2]        = st_reg.pc.watch_cc2;
    state_word[`CCD_ST_ADV1 +: 3] = st_reg.adv1;
    state_word[`CCD_ST_ADV2 +: 3] = st_reg.adv2;
    state_word[`CCD_ST_SATT]      = st_reg.snk_att;
  end

  always_comb begin
    st_next     = st_reg;
    st_next.ack = req & ~st_reg.ack;

    // ----------------------------------------
    // connection decode
    // ----------------------------------------
    // the comparator reads nonsense while the pull-up is steered to the
    // strap, so the last decision is held over that window
    if (!strap_sample_in) begin
      st_next.adv1 = sink_adv(m1);
      st_next.adv2 = sink_adv(m2);
      st_next.snk_att = bus_power_sense_pin_in &
                        (st_next.adv1 != cc_detect_pkg::ADV_NONE ||
                         st_next.adv2 != cc_detect_pkg::ADV_NONE);
      st_next.pc = '0;
      st_next.pc.watch_cc1 = 1'b1;
      st_next.pc.watch_cc2 = 1'b1;
      if (is_sink || rp == `CCD_RP_OFF) begin
        st_next.conn = is_sink ? cc_detect_pkg::CONN_SNK_MODE : cc_detect_pkg::CONN_NONE;
      end else begin
        unique case ({c1, c2})
          {cc_detect_pkg::LINE_OPEN, cc_detect_pkg::LINE_OPEN}: begin
            st_next.conn = cc_detect_pkg::CONN_NONE;
          end
          {cc_detect_pkg::LINE_RD, cc_detect_pkg::LINE_OPEN},
          {cc_detect_pkg::LINE_OPEN, cc_detect_pkg::LINE_RD}: begin
            st_next.conn = cc_detect_pkg::CONN_SINK;
            st_next.pc.vbus = 1'b1;
            st_next.pc.watch_cc1 = (c1 == cc_detect_pkg::LINE_RD);
            st_next.pc.watch_cc2 = (c2 == cc_detect_pkg::LINE_RD);
          end
          {cc_detect_pkg::LINE_RA, cc_detect_pkg::LINE_OPEN},
          {cc_detect_pkg::LINE_OPEN, cc_detect_pkg::LINE_RA}: begin
            st_next.conn = cc_detect_pkg::CONN_CABLE;
          end
          {cc_detect_pkg::LINE_RA, cc_detect_pkg::LINE_RD},
          {cc_detect_pkg::LINE_RD, cc_detect_pkg::LINE_RA}: begin
            st_next.conn = cc_detect_pkg::CONN_CABLE_SINK;
            st_next.pc.vbus = 1'b1;
            st_next.pc.vconn = 1'b1;
            st_next.pc.vconn_cc2 = (c2 == cc_detect_pkg::LINE_RA);
            st_next.pc.watch_cc1 = (c1 == cc_detect_pkg::LINE_RD);
            st_next.pc.watch_cc2 = (c2 == cc_detect_pkg::LINE_RD);
          end
          {cc_detect_pkg::LINE_RD, cc_detect_pkg::LINE_RD}: begin
            st_next.conn = cc_detect_pkg::CONN_DEBUG;
          end
          default: begin
            st_next.conn = cc_detect_pkg::CONN_AUDIO;
          end
        endcase
      end
    end

    // ----------------------------------------
    // pull-up drive
    // ----------------------------------------
    st_next.rp_out = strap_sample_in ? `CCD_RP_OFF : rp;

    // ----------------------------------------
    // register access
    // ----------------------------------------
    st_next.rdata = '0;
    if (avl_in.read && !st_reg.ack) begin
      unique case (avl_in.address)
        `CCD_OFS_CTRL:  st_next.rdata = {28'h0000000, st_reg.ctrl};
        `CCD_OFS_MATCH: st_next.rdata = {16'h0000, m2, m1};
        `CCD_OFS_STATE: st_next.rdata = state_word;
        `CCD_OFS_STS:   st_next.rdata = {28'h0000000, st_reg.sts};
        `CCD_OFS_MASK:  st_next.rdata = {28'h0000000, st_reg.mask};
        default:        st_next.rdata = '0;
      endcase
    end
    if (wr_ok && avl_in.address == `CCD_OFS_CTRL) begin
      st_next.ctrl = avl_in.writedata[3:0];
    end
    if (wr_ok && avl_in.address == `CCD_OFS_MASK) begin
      st_next.mask = avl_in.writedata[3:0];
    end
    if (wr_ok && avl_in.address == `CCD_OFS_STS) begin
      st_next.sts = st_reg.sts & ~avl_in.writedata[3:0];
    end

    // ----------------------------------------
    // events; a set in the clearing cycle wins
    // ----------------------------------------
    st_next.sts[`CCD_EV_CC1] = st_next.sts[`CCD_EV_CC1] | m_chg[0];
    st_next.sts[`CCD_EV_CC2] = st_next.sts[`CCD_EV_CC2] | m_chg[1];
    st_next.sts[`CCD_EV_CONN] = st_next.sts[`CCD_EV_CONN] |
                                (st_next.conn != st_reg.conn);
    st_next.sts[`CCD_EV_SNK] = st_next.sts[`CCD_EV_SNK] |
                               (st_next.snk_att != st_reg.snk_att);
    st_next.irq = |(st_next.sts & st_next.mask);

    if (srst_in) begin
      st_next = '0;
      st_next.ctrl = `CCD_CTRL_RST;
      st_next.mask = `CCD_MASK_RST;
      st_next.conn = cc_detect_pkg::CONN_NONE;
      st_next.pc.watch_cc1 = 1'b1;
      st_next.pc.watch_cc2 = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    st_reg <= st_next;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign avl_waitrequest_out       = req & ~st_reg.ack;
  assign avl_readdata_out          = st_reg.rdata;
  assign pullup_current_select_out = st_reg.rp_out;
  assign vbus_en_out               = st_reg.pc.vbus;
  assign vconn_en_out              = st_reg.pc.vconn;
  assign vconn_cc2_out             = st_reg.pc.vconn_cc2;
  assign watch_cc1_out             = st_reg.pc.watch_cc1;
  assign watch_cc2_out             = st_reg.pc.watch_cc2;
  assign irq_out                   = st_reg.irq;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (srst_in);

  logic src_def;
  logic src_3a0;
  assign src_def = !is_sink && rp == `CCD_RP_DEF && !st_reg.ctrl[`CCD_CTRL_VHC] && !strap_sample_in;
  assign src_3a0 = !is_sink && rp == `CCD_RP_3A0 && !st_reg.ctrl[`CCD_CTRL_VHC] && !strap_sample_in;

  chk_match_capture: assert property (##1 m1 == $past(cc1_cmp_in) && m2 == $past(cc2_cmp_in))
    else $error("match vector not registered from comparator");
  chk_strap_rp_off: assert property (strap_sample_in |=> pullup_current_select_out == `CCD_RP_OFF)
    else $error("pull-up advertised during strap sampling");
  chk_rp_code_out: assert property (!strap_sample_in |=> pullup_current_select_out == $past(rp))
    else $error("pull-up code differs from programmed code");
  chk_open_3a0_none: assert property (src_3a0 && m1 == 8'h48 && m2 == 8'h48 |=> conn_is(cc_detect_pkg::CONN_NONE))
    else $error("open lines at 3.0 A not seen as unattached");
  chk_sink_attach: assert property (src_def && m1 == 8'h01 && m2 == 8'h21
                                    |=> conn_is(cc_detect_pkg::CONN_SINK) && watch_cc1_out && !watch_cc2_out)
    else $error("rd on cc1 not taken as sink attach");
  chk_cable_only: assert property (src_def && m1 == 8'h00 && m2 == 8'h21 |=> conn_is(cc_detect_pkg::CONN_CABLE))
    else $error("ra with open not taken as cable only");
  chk_sink_power: assert property (conn_is(cc_detect_pkg::CONN_SINK) |-> vbus_en_out && !vconn_en_out)
    else $error("sink attached without vbus or with vconn");
  chk_cable_sink_pwr: assert property (conn_is(cc_detect_pkg::CONN_CABLE_SINK)
                                       |-> vbus_en_out && vconn_en_out && (watch_cc1_out ^ watch_cc2_out))
    else $error("cable with sink lacks power or watches both");
  chk_idle_power_off: assert property (conn_is(cc_detect_pkg::CONN_NONE) || conn_is(cc_detect_pkg::CONN_DEBUG) ||
                                       conn_is(cc_detect_pkg::CONN_AUDIO) || conn_is(cc_detect_pkg::CONN_CABLE)
                                       |-> !vbus_en_out && !vconn_en_out && watch_cc1_out && watch_cc2_out)
    else $error("power on or single watch without sink");
  chk_sink_level: assert property (is_sink && !strap_sample_in && m1 == 8'h15
                                   |=> st_reg.adv1 == cc_detect_pkg::ADV_3A0)
    else $error("3.0 A source level not decoded");
  chk_change_event: assert property (m_chg[0] |=> st_reg.sts[`CCD_EV_CC1] ##1 1'b1)
    else $error("match change not flagged");
  chk_irq_level: assert property (st_reg.mask[`CCD_EV_CC1] && m_chg[0] |=> irq_out)
    else $error("unmasked event did not raise interrupt");

  cov_sink_attach: cover property (conn_is(cc_detect_pkg::CONN_NONE) ##1 conn_is(cc_detect_pkg::CONN_SINK));
  cov_cable_sink: cover property (conn_is(cc_detect_pkg::CONN_CABLE_SINK));
  cov_debug: cover property (conn_is(cc_detect_pkg::CONN_DEBUG));
  cov_sink_vhc: cover property (st_reg.adv1 == cc_detect_pkg::ADV_VHC && st_reg.snk_att);

  function automatic logic conn_is(input cc_detect_pkg::conn_state_type c);
    return st_reg.conn == c;
  endfunction : conn_is

endmodule : typec_cc_attach_detect

`default_nettype wire

/* File: tb/cc_port_partner.sv */
/*
  port partner model: turns the termination on each cc line, the applied
  pull-up code and a source level into comparator match vectors.
  assumes terminations are 0 open, 1 rd, 2 ra and inputs change off the edge.
*/
`default_nettype none

module cc_port_partner (
  input  wire logic [1:0] rp_in,
  input  wire logic       vhc_in,
  input  wire logic       snk_in,
  input  wire logic [1:0] term1_in,
  input  wire logic [1:0] term2_in,
  input  wire logic [2:0] adv_in,
  output logic      [7:0] cc1_out,
  output logic      [7:0] cc2_out
);
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------
  // line levels
  // ----------------------------------------
  function automatic logic [7:0] lvl(input logic [1:0] t, input logic [1:0] rp, input logic vhc);
    logic [7:0] v;
    v = 8'h00;
    if (t == 2'h1) begin
      v = (rp == 2'h1) ? 8'h01 : (rp == 2'h2) ? 8'h02 : 8'h08;
    end else if (t == 2'h0) begin
      v = vhc ? 8'h80 : (rp == 2'h1) ? 8'h21 : (rp == 2'h2) ? 8'h22 : 8'h48;
    end
    // no pull-up current means no voltage at all
    if (rp == 2'h0) begin
      v = 8'h00;
    end
    return v;
  endfunction : lvl

  always_comb begin
    if (snk_in) begin
      // source partner drives cc1 only, cc2 stays unterminated
      cc1_out = {adv_in == 3'h4, 2'h0, adv_in >= 3'h3, 1'b0, adv_in >= 3'h2, 1'b0, adv_in != 3'h0};
      cc2_out = 8'h00;
    end else begin
      cc1_out = lvl(term1_in, rp_in, vhc_in);
      cc2_out = lvl(term2_in, rp_in, vhc_in);
    end
  end
endmodule : cc_port_partner

`default_nettype wire

/* File: tb/typec_cc_attach_detect_tb_top.sv */
/*
  self-checking bench of the cc attach and detach detector.
  assumes the design's one-wait-cycle avalon slave and a two-edge comparator path.
*/
`include "cc_detect_cfg.svh"
`default_nettype none

module typec_cc_attach_detect_tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic                       clk_sys_in  = 1'b0;
  logic                       srst_in     = 1'b1;
  logic                       strap       = 1'b0;
  logic                       snk         = 1'b0;
  logic                       vhc         = 1'b0;
  logic [1:0]                 t1          = 2'h0;
  logic [1:0]                 t2          = 2'h0;
  logic [2:0]                 adv         = 3'h0;
  logic                       vsense      = 1'b1;
  cc_detect_pkg::avl_req_type avl         = '0;
  logic [7:0]                 cc1, cc2;
  logic [31:0]                rdata, q;
  logic [1:0]                 rp;
  logic                       waitreq, vbus, vconn, vcc2, w1, w2, irq;
  int                         n_errors    = 0;
  int                         checks_done = 0;
  int                         cycles      = 0;
  // {term1, term2, vbus, vconn, vconn on cc2, watch1, watch2, conn}
  localparam logic [15:0] tbl [9] = '{16'h0181, 16'h4902, 16'h1882, 16'h8184, 16'h2184,
                                      16'h9c88, 16'h6f08, 16'h5190, 16'ha1a0};

  always #20 clk_sys_in = ~clk_sys_in;

  typec_cc_attach_detect typec_cc_attach_detect_inst (
    .clk_sys_in(clk_sys_in), .srst_in(srst_in), .avl_in(avl), .avl_readdata_out(rdata),
    .avl_waitrequest_out(waitreq), .cc1_cmp_in(cc1), .cc2_cmp_in(cc2), .strap_sample_in(strap),
    .bus_power_sense_pin_in(vsense), .pullup_current_select_out(rp), .vbus_en_out(vbus),
    .vconn_en_out(vconn), .vconn_cc2_out(vcc2), .watch_cc1_out(w1), .watch_cc2_out(w2), .irq_out(irq));

  cc_port_partner cc_port_partner_inst (
    .rp_in(rp), .vhc_in(vhc), .snk_in(snk), .term1_in(t1), .term2_in(t2), .adv_in(adv),
    .cc1_out(cc1), .cc2_out(cc2));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    avl <= '{read: !w, write: w, address: a, byteenable: 4'hf, writedata: d};
    @(posedge clk_sys_in);
    while (waitreq !== 1'b0) @(posedge clk_sys_in);
    q = rdata;
    avl <= '0;
    // one idle edge so the next request never lands in the release time step
    @(posedge clk_sys_in);
  endtask : bus

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic settle;
    repeat (4) @(posedge clk_sys_in);
  endtask : settle

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    bus(1'b0, `CCD_OFS_CTRL, 32'h0);
    chk(q, 32'h2);
    bus(1'b0, `CCD_OFS_MASK, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, `CCD_OFS_STATE, 32'h0);
    chk(q & 32'hf7f, 32'hc01);
    bus(1'b1, 5'h14, 32'hffffffff);
    bus(1'b0, 5'h14, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, `CCD_OFS_CTRL, 32'h0);
    chk(q, 32'h2);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_conn;
    logic [15:0] e;
    for (int i = 0; i < 9; i++) begin
      e = tbl[i];
      t1 <= e[15:14];
      t2 <= e[13:12];
      settle();
      chk({vbus, vconn, w1, w2}, {e[11:10], e[8:7]});
      if (e[10]) chk(vcc2, e[9]);
      bus(1'b0, `CCD_OFS_STATE, 32'h0);
      chk(q[6:0], e[6:0]);
      bus(1'b0, `CCD_OFS_MATCH, 32'h0);
      chk(q[15:0], {cc2, cc1});
    end
    $display("t_conn done");
  endtask : t_conn

  task automatic t_rp;
    t1 <= 2'h1;
    t2 <= 2'h0;
    for (int c = 1; c < 4; c++) begin
      bus(1'b1, `CCD_OFS_CTRL, c << 1);
      settle();
      chk(rp, c[1:0]);
      chk(vbus, 1'b1);
    end
    bus(1'b1, `CCD_OFS_CTRL, 32'h0);
    settle();
    chk({rp, vbus}, 3'h0);
    vhc <= 1'b1;
    bus(1'b1, `CCD_OFS_CTRL, 32'ha);
    settle();
    chk({rp, vbus}, 3'h3);
    vhc <= 1'b0;
    bus(1'b1, `CCD_OFS_CTRL, 32'h2);
    settle();
    $display("t_rp done");
  endtask : t_rp

  task automatic t_strap;
    strap <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    chk({rp, vbus}, 3'h1);
    strap <= 1'b0;
    settle();
    chk({rp, vbus}, 3'h3);
    $display("t_strap done");
  endtask : t_strap

  task automatic t_irq;
    bus(1'b1, `CCD_OFS_MASK, 32'h1);
    bus(1'b1, `CCD_OFS_STS, 32'hf);
    chk(irq, 1'b0);
    t1 <= 2'h0;
    settle();
    chk(irq, 1'b1);
    bus(1'b1, `CCD_OFS_STS, 32'h1);
    chk(irq, 1'b0);
    bus(1'b1, `CCD_OFS_MASK, 32'h0);
    t1 <= 2'h1;
    settle();
    chk(irq, 1'b0);
    bus(1'b0, `CCD_OFS_STS, 32'h0);
    chk(q[0], 1'b1);
    $display("t_irq done");
  endtask : t_irq

  task automatic t_sink;
    snk <= 1'b1;
    bus(1'b1, `CCD_OFS_CTRL, 32'h1);
    for (int a = 0; a < 5; a++) begin
      adv <= a[2:0];
      settle();
      bus(1'b0, `CCD_OFS_STATE, 32'h0);
      chk(q[14:12], a[2:0]);
      chk({q[18], q[6:0], vbus}, {a != 0, 7'h40, 1'b0});
    end
    // without bus power the advertised level alone is no attach
    vsense <= 1'b0;
    settle();
    bus(1'b0, `CCD_OFS_STATE, 32'h0);
    chk({q[18], q[14:12]}, 4'h4);
    vsense <= 1'b1;
    $display("t_sink done");
  endtask : t_sink

  // ----------------------------------------
  // run and timeout
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    @(posedge clk_sys_in);
    t_reset();
    t_conn();
    t_rp();
    t_strap();
    t_irq();
    t_sink();
    wrap_up();
  end

  // the whole run needs well under a thousand cycles
  always @(posedge clk_sys_in) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      n_errors++;
      wrap_up();
    end
  end
endmodule : typec_cc_attach_detect_tb_top

`default_nettype wire
